// ### logic/cscr_pkg.sv
// Purpose: shared constants for the converter start-up configuration block
// Assumes: apb byte addressing, one 32-bit word per register
// Notes:   printed offsets are indexes; byte address is four times the index
package cscr_pkg;

  localparam int unsigned ADDR_W = 18;

  // register indexes and byte addresses
  localparam logic [15:0]       CFG_INDEX   = 16'h7812;
  localparam logic [15:0]       STAT_INDEX  = 16'h7820;
  localparam logic [ADDR_W-1:0] CFG_ADDR    = ADDR_W'({CFG_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] STAT_ADDR   = ADDR_W'({STAT_INDEX, 2'b00});

  // configuration register field positions
  localparam int unsigned SLOT4_LSB  = 13;
  localparam int unsigned VSEL4_LSB  = 8;
  localparam int unsigned SLOT3_LSB  = 5;
  localparam int unsigned VSEL3_LSB  = 0;
  localparam int unsigned SLOT_W     = 3;
  localparam int unsigned VSEL_W     = 5;
  localparam int unsigned CODE_W     = 7;
  localparam int unsigned MV_W       = 12;

  // reset value and slot field codes
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [SLOT_W-1:0] SLOT_NEVER = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_HW1   = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_HW2   = 3'h7;

  // status register bit positions
  localparam int unsigned ST_BOOT_LOADED = 0;
  localparam int unsigned ST_CLAMP3      = 1;
  localparam int unsigned ST_CLAMP4      = 2;
  localparam int unsigned ST_MODE3_LSB   = 3;
  localparam int unsigned ST_MODE4_LSB   = 5;

  // output voltage law, millivolts
  localparam logic [MV_W-1:0]   BASE_MV  = 12'h352;
  localparam logic [MV_W-1:0]   STEP_MV  = 12'h019;
  localparam logic [MV_W-1:0]   MAX_MV   = 12'hD48;
  localparam logic [CODE_W-1:0] SAT_CODE = 7'h66;
  localparam logic [MV_W-1:0]   COARSE_STEP_MV = 12'h064;

  typedef enum logic [1:0] {
    CSCR_MODE_NEVER = 2'b00,
    CSCR_MODE_SLOT  = 2'b01,
    CSCR_MODE_HW1   = 2'b10,
    CSCR_MODE_HW2   = 2'b11
  } cscr_mode_e;

endpackage : cscr_pkg

// ### logic/cscr_conv_decode.sv
// Purpose: decode one converter's slot and voltage fields
// Assumes: slot and high voltage fields come straight from register flops, low code bits from input ports
// Notes:   purely combinational; clock only serves the checks
`timescale 1ns/1ps
module cscr_conv_decode (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [cscr_pkg::SLOT_W-1:0]   slot_field,
  input  wire logic [cscr_pkg::VSEL_W-1:0]   vsel_high,
  input  wire logic [1:0]                    vsel_low,
  output cscr_pkg::cscr_mode_e               start_mode,
  output logic      [cscr_pkg::SLOT_W-1:0]   timeslot_index,
  output logic      [cscr_pkg::CODE_W-1:0]   voltage_code,
  output logic      [cscr_pkg::MV_W-1:0]     voltage_mv,
  output logic                               voltage_clamped
);

  logic [cscr_pkg::MV_W-1:0] linear_mv;

  always_comb begin
    timeslot_index = cscr_pkg::SLOT_NEVER;
    case (slot_field)
      cscr_pkg::SLOT_NEVER: start_mode = cscr_pkg::CSCR_MODE_NEVER;
      cscr_pkg::SLOT_HW1:   start_mode = cscr_pkg::CSCR_MODE_HW1;
      cscr_pkg::SLOT_HW2:   start_mode = cscr_pkg::CSCR_MODE_HW2;
      default: begin
        // codes 1..5 name the timeslot directly
        start_mode     = cscr_pkg::CSCR_MODE_SLOT;
        timeslot_index = slot_field;
      end
    endcase
  end

  assign voltage_code = {vsel_high, vsel_low};
  assign linear_mv    = cscr_pkg::MV_W'(cscr_pkg::BASE_MV
                        + cscr_pkg::MV_W'(voltage_code) * cscr_pkg::STEP_MV);

  // saturate, never wrap, above the top code
  assign voltage_clamped = (voltage_code >= cscr_pkg::SAT_CODE);
  assign voltage_mv      = voltage_clamped ? cscr_pkg::MAX_MV : linear_mv;

  chk_slot_mode_map: assert property (@(posedge pclk) disable iff (!presetn)
    (slot_field == cscr_pkg::SLOT_NEVER) == (start_mode == cscr_pkg::CSCR_MODE_NEVER)
    && ((slot_field > cscr_pkg::SLOT_NEVER && slot_field <= cscr_pkg::SLOT_LAST)
        == (start_mode == cscr_pkg::CSCR_MODE_SLOT && timeslot_index == slot_field)))
    else $error("slot field decoded to wrong mode");

  chk_slot_hw_map: assert property (@(posedge pclk) disable iff (!presetn)
    slot_field >= cscr_pkg::SLOT_HW1 |-> timeslot_index == cscr_pkg::SLOT_NEVER
      && (start_mode == cscr_pkg::CSCR_MODE_HW1) == (slot_field == cscr_pkg::SLOT_HW1)
      && (start_mode == cscr_pkg::CSCR_MODE_HW2) == (slot_field == cscr_pkg::SLOT_HW2))
    else $error("hardware enable slot decoded wrong");

  chk_volt_linear: assert property (@(posedge pclk) disable iff (!presetn)
    voltage_code < cscr_pkg::SAT_CODE |->
      voltage_mv == 12'(850 + 25 * int'(voltage_code)) && !voltage_clamped)
    else $error("voltage not linear below saturation");

  chk_volt_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    voltage_code >= 7'h66 |-> voltage_mv == 12'd3400 && voltage_clamped)
    else $error("saturated code did not clamp");

  // coarse step of the high field
  chk_coarse_step: assert property (@(posedge pclk) disable iff (!presetn)
    // widened so a 1F to 00 wrap is not taken for a step
    (voltage_code < 7'h62 && $stable(vsel_low)
      && {1'b0, vsel_high} == {1'b0, $past(vsel_high)} + 6'h01)
      |-> voltage_mv == $past(voltage_mv) + cscr_pkg::COARSE_STEP_MV)
    else $error("coarse step is not one hundred millivolts");

endmodule : cscr_conv_decode

// ### logic/cscr_top.sv
// Purpose: start-up configuration register for converters three and four
// Assumes: apb slave, zero wait states, bootstrap loader has a word port
// Notes:   bootstrap load wins over a same-cycle software write
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - fourth converter slot bits 15:13, reset 000: never, slots 1-5, hardware enables
// - third converter slot bits 7:5, reset 000, same encoding as the fourth
// - bits 12:8 hold fourth voltage code bits 6:2, 100mV per step
// - fourth voltage code: 0.85V at 00h, 25mV per code, 66h up is 3.4V
// - bits 4:0 hold third voltage code bits 6:2, reset zero, 100mV per step
// - third voltage code: same linear law, codes 66h to 7Fh clamp to 3.4V
module cscr_top #(
  parameter int unsigned ADDR_W = cscr_pkg::ADDR_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        boot_load_valid,
  input  wire logic [15:0]                 boot_load_data,
  input  wire logic [1:0]                  conv_three_code_low,
  input  wire logic [1:0]                  conv_four_code_low,
  output cscr_pkg::cscr_mode_e             conv_three_start_mode,
  output logic      [cscr_pkg::SLOT_W-1:0] conv_three_start_slot,
  output logic      [cscr_pkg::CODE_W-1:0] conv_three_code,
  output logic      [cscr_pkg::MV_W-1:0]   conv_three_start_mv,
  output cscr_pkg::cscr_mode_e             conv_four_start_mode,
  output logic      [cscr_pkg::SLOT_W-1:0] conv_four_start_slot,
  output logic      [cscr_pkg::CODE_W-1:0] conv_four_code,
  output logic      [cscr_pkg::MV_W-1:0]   conv_four_start_mv
);

  logic [15:0]                 cfg_reg;
  logic [15:0]                 cfg_next;
  logic                        boot_loaded_reg;
  logic [31:0]                 prdata_reg;
  logic [31:0]                 status_word;
  logic                        setup;
  logic                        access;
  logic                        hit_cfg;
  logic                        hit_stat;
  logic                        unmapped;
  logic                        wr_cfg;
  logic                        clr_boot;
  logic                        clamp3;
  logic                        clamp4;
  logic [cscr_pkg::SLOT_W-1:0] conv_four_start_timeslot;
  logic [cscr_pkg::VSEL_W-1:0] conv_four_start_voltage_code;
  logic [cscr_pkg::SLOT_W-1:0] conv_three_start_timeslot;
  logic [cscr_pkg::VSEL_W-1:0] conv_three_start_voltage_code;

  // bus decode
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_cfg  = (paddr == cscr_pkg::CFG_ADDR);
  assign hit_stat = (paddr == cscr_pkg::STAT_ADDR);
  assign unmapped = !hit_cfg && !hit_stat;
  assign wr_cfg   = access && pwrite && hit_cfg;
  assign clr_boot = access && pwrite && hit_stat && pstrb[0]
                    && pwdata[cscr_pkg::ST_BOOT_LOADED];

  // always ready: every read is captured in a flop at setup, nothing to wait for
  assign pready  = 1'b1;
  assign pslverr = access && unmapped;
  assign prdata  = prdata_reg;

  assign conv_four_start_timeslot      = cfg_reg[cscr_pkg::SLOT4_LSB +: cscr_pkg::SLOT_W];
  assign conv_four_start_voltage_code  = cfg_reg[cscr_pkg::VSEL4_LSB +: cscr_pkg::VSEL_W];
  assign conv_three_start_timeslot     = cfg_reg[cscr_pkg::SLOT3_LSB +: cscr_pkg::SLOT_W];
  assign conv_three_start_voltage_code = cfg_reg[cscr_pkg::VSEL3_LSB +: cscr_pkg::VSEL_W];

  // byte lanes: lane 1 holds the fourth converter, lane 0 the third
  always_comb begin
    cfg_next = cfg_reg;
    if (boot_load_valid) begin
      cfg_next = boot_load_data;
    end else if (wr_cfg) begin
      if (pstrb[1]) begin
        cfg_next[15:8] = pwdata[15:8];
      end
      if (pstrb[0]) begin
        cfg_next[7:0] = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= cscr_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // sticky load flag; a load in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_loaded_reg <= 1'b0;
    end else if (boot_load_valid) begin
      boot_loaded_reg <= 1'b1;
    end else if (clr_boot) begin
      boot_loaded_reg <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[cscr_pkg::ST_BOOT_LOADED]     = boot_loaded_reg;
    status_word[cscr_pkg::ST_CLAMP3]          = clamp3;
    status_word[cscr_pkg::ST_CLAMP4]          = clamp4;
    status_word[cscr_pkg::ST_MODE3_LSB +: 2]  = conv_three_start_mode;
    status_word[cscr_pkg::ST_MODE4_LSB +: 2]  = conv_four_start_mode;
  end

  // read data captured in the setup phase, stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (hit_cfg) begin
        prdata_reg <= {16'h0000, cfg_next};
      end else if (hit_stat) begin
        prdata_reg <= status_word;
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  cscr_conv_decode u_dec_three (
    .pclk            (pclk),
    .presetn         (presetn),
    .slot_field      (conv_three_start_timeslot),
    .vsel_high       (conv_three_start_voltage_code),
    .vsel_low        (conv_three_code_low),
    .start_mode      (conv_three_start_mode),
    .timeslot_index  (conv_three_start_slot),
    .voltage_code    (conv_three_code),
    .voltage_mv      (conv_three_start_mv),
    .voltage_clamped (clamp3)
  );

  cscr_conv_decode u_dec_four (
    .pclk            (pclk),
    .presetn         (presetn),
    .slot_field      (conv_four_start_timeslot),
    .vsel_high       (conv_four_start_voltage_code),
    .vsel_low        (conv_four_code_low),
    .start_mode      (conv_four_start_mode),
    .timeslot_index  (conv_four_start_slot),
    .voltage_code    (conv_four_code),
    .voltage_mv      (conv_four_start_mv),
    .voltage_clamped (clamp4)
  );

  chk_slot4_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && pstrb[1] && !boot_load_valid)
      |=> conv_four_start_timeslot == $past(pwdata[15:13]))
    else $error("fourth slot field not written");

  chk_slot3_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && pstrb[0] && !boot_load_valid)
      |=> conv_three_start_timeslot == $past(pwdata[7:5]))
    else $error("third slot field not written");

  chk_vsel4_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && pstrb[1] && !boot_load_valid)
      |=> conv_four_code[6:2] == $past(pwdata[12:8]))
    else $error("fourth voltage field not at code bits six to two");

  chk_vsel3_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && pstrb[0] && !boot_load_valid)
      |=> conv_three_code[6:2] == $past(pwdata[4:0]))
    else $error("third voltage field not at code bits six to two");

  chk_lane_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && !pstrb[0] && !boot_load_valid) |=> $stable(cfg_reg[7:0]))
    else $error("unstrobed low lane changed");

  chk_boot_wins: assert property (@(posedge pclk) disable iff (!presetn)
    boot_load_valid |=> cfg_reg == $past(boot_load_data) && boot_loaded_reg)
    else $error("bootstrap load not taken");

  chk_four_volt_out: assert property (@(posedge pclk) disable iff (!presetn)
    conv_four_code >= 7'h66 |-> conv_four_start_mv == 12'd3400)
    else $error("fourth converter voltage not clamped");

  chk_read_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_cfg && !boot_load_valid) ##1 (access && !wr_cfg)
      |-> prdata[15:0] == cfg_reg && prdata[31:16] == 16'h0000)
    else $error("read data does not show the register");

  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (access && unmapped) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  chk_reset_values: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> cfg_reg == cscr_pkg::CFG_RESET && !boot_loaded_reg
      && prdata == 32'h0000_0000)
    else $error("register not at reset value after release");

  chk_lane_high_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cfg && !pstrb[1] && !boot_load_valid) |=> $stable(cfg_reg[15:8]))
    else $error("unstrobed high lane changed");

  chk_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_cfg && !boot_load_valid) |=> $stable(cfg_reg))
    else $error("register changed without a write or load");

  chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !unmapped) |-> !pslverr)
    else $error("mapped access flagged as error");

  chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && unmapped) ##1 access |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_read_stat: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_stat) ##1 access |-> prdata == $past(status_word))
    else $error("status read does not match status word");

  chk_boot_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_boot && !boot_load_valid) |=> !boot_loaded_reg)
    else $error("load flag not cleared");

  chk_boot_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (!clr_boot && !boot_load_valid) |=> $stable(boot_loaded_reg))
    else $error("load flag changed on its own");

  chk_status_flags: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[cscr_pkg::ST_CLAMP3] == (conv_three_code >= 7'h66)
      && status_word[cscr_pkg::ST_CLAMP4] == (conv_four_code >= 7'h66)
      && status_word[cscr_pkg::ST_MODE3_LSB +: 2] == conv_three_start_mode
      && status_word[cscr_pkg::ST_MODE4_LSB +: 2] == conv_four_start_mode)
    else $error("status word does not mirror the decode");

  chk_slot4_range: assert property (@(posedge pclk) disable iff (!presetn)
    conv_four_start_mode == cscr_pkg::CSCR_MODE_SLOT
      |-> conv_four_start_slot != 3'h0 && conv_four_start_slot <= 3'h5)
    else $error("fourth timeslot out of range");

  chk_slot3_range: assert property (@(posedge pclk) disable iff (!presetn)
    conv_three_start_mode == cscr_pkg::CSCR_MODE_SLOT
      |-> conv_three_start_slot != 3'h0 && conv_three_start_slot <= 3'h5)
    else $error("third timeslot out of range");

  chk_slot4_never: assert property (@(posedge pclk) disable iff (!presetn)
    conv_four_start_timeslot == 3'h0
      |-> conv_four_start_mode == cscr_pkg::CSCR_MODE_NEVER && conv_four_start_slot == 3'h0)
    else $error("fourth converter not left disabled");

  chk_slot3_hw: assert property (@(posedge pclk) disable iff (!presetn)
    conv_three_start_timeslot == 3'h6
      |-> conv_three_start_mode == cscr_pkg::CSCR_MODE_HW1 && conv_three_start_slot == 3'h0)
    else $error("third converter not on first hardware enable");

  chk_four_volt_step: assert property (@(posedge pclk) disable iff (!presetn)
    conv_four_code < 7'h66
      |-> conv_four_start_mv == 12'(850 + 25 * int'(conv_four_code)))
    else $error("fourth converter voltage not linear");

  chk_three_volt_out: assert property (@(posedge pclk) disable iff (!presetn)
    conv_three_code >= 7'h66 |-> conv_three_start_mv == 12'd3400)
    else $error("third converter voltage not clamped");

  chk_three_volt_base: assert property (@(posedge pclk) disable iff (!presetn)
    conv_three_code == 7'h00 |-> conv_three_start_mv == 12'd850)
    else $error("third converter bottom code wrong");

  cov_boot_load: cover property (@(posedge pclk) disable iff (!presetn)
    boot_load_valid ##1 access && !pwrite && hit_cfg);
  cov_hw_enable: cover property (@(posedge pclk) disable iff (!presetn)
    conv_four_start_mode == cscr_pkg::CSCR_MODE_HW2
      && conv_three_start_mode == cscr_pkg::CSCR_MODE_HW1);
  cov_clamp: cover property (@(posedge pclk) disable iff (!presetn) clamp3 && clamp4);
  cov_slot_five: cover property (@(posedge pclk) disable iff (!presetn)
    conv_three_start_slot == 3'h5);

endmodule : cscr_top

// ### verification/cscr_top_bench.sv
// Purpose: self-checking bench for the converter start-up configuration block
// Assumes: zero wait-state apb slave, outputs decode from register contents
// Notes:   outputs are sampled on the falling edge, after write updates land
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (act), (exp)); end end
module cscr_top_bench;
  logic                         pclk = 1'b0;
  logic                         presetn = 1'b0;
  logic [cscr_pkg::ADDR_W-1:0]  paddr = '0;
  logic                         psel = 1'b0;
  logic                         penable = 1'b0;
  logic                         pwrite = 1'b0;
  logic [31:0]                  pwdata = '0;
  logic [3:0]                   pstrb = '0;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         boot_load_valid = 1'b0;
  logic [15:0]                  boot_load_data = '0;
  logic [1:0]                   conv_three_code_low = 2'h3;
  logic [1:0]                   conv_four_code_low = 2'h1;
  cscr_pkg::cscr_mode_e         conv_three_start_mode;
  logic [cscr_pkg::SLOT_W-1:0]  conv_three_start_slot;
  logic [cscr_pkg::CODE_W-1:0]  conv_three_code;
  logic [cscr_pkg::MV_W-1:0]    conv_three_start_mv;
  cscr_pkg::cscr_mode_e         conv_four_start_mode;
  logic [cscr_pkg::SLOT_W-1:0]  conv_four_start_slot;
  logic [cscr_pkg::CODE_W-1:0]  conv_four_code;
  logic [cscr_pkg::MV_W-1:0]    conv_four_start_mv;
  logic [31:0]                  rdata;
  logic                         serr;
  int                           error_cnt = 0;
  int                           cmp_count = 0;

  always #4 pclk = ~pclk;

  cscr_top i_cscr_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_load_valid(boot_load_valid),
    .boot_load_data(boot_load_data), .conv_three_code_low(conv_three_code_low),
    .conv_four_code_low(conv_four_code_low), .conv_three_start_mode(conv_three_start_mode),
    .conv_three_start_slot(conv_three_start_slot), .conv_three_code(conv_three_code),
    .conv_three_start_mv(conv_three_start_mv), .conv_four_start_mode(conv_four_start_mode),
    .conv_four_start_slot(conv_four_start_slot), .conv_four_code(conv_four_code),
    .conv_four_start_mv(conv_four_start_mv));

  function automatic cscr_pkg::cscr_mode_e exp_mode(input logic [2:0] s);
    if (s == 3'h0) return cscr_pkg::CSCR_MODE_NEVER;
    if (s == 3'h6) return cscr_pkg::CSCR_MODE_HW1;
    if (s == 3'h7) return cscr_pkg::CSCR_MODE_HW2;
    return cscr_pkg::CSCR_MODE_SLOT;
  endfunction : exp_mode

  function automatic logic [2:0] exp_slot(input logic [2:0] s);
    return (s >= 3'h1 && s <= 3'h5) ? s : 3'h0;
  endfunction : exp_slot

  // saturated codes clamp to the top value instead of wrapping
  function automatic logic [11:0] exp_mv(input logic [6:0] c);
    if (c >= 7'h66) return 12'hD48;
    return 12'(12'h352 + 12'h019 * c);
  endfunction : exp_mv

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // one apb transfer; boot raises the load pulse in the access cycle
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic boot);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    boot_load_valid <= boot;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      end_of_test;
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    boot_load_valid <= 1'b0;
  endtask : apb

  task automatic wr_cfg(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, cscr_pkg::CFG_ADDR, d, s, 1'b0);
    `CHK(serr, 1'b0)
  endtask : wr_cfg

  // register read-back plus every decoded output
  task automatic chk_dec(input logic [15:0] v);
    logic [6:0] c3;
    logic [6:0] c4;
    @(negedge pclk);
    c4 = {v[12:8], conv_four_code_low};
    c3 = {v[4:0], conv_three_code_low};
    `CHK(conv_four_start_mode, exp_mode(v[15:13]))
    `CHK(conv_four_start_slot, exp_slot(v[15:13]))
    `CHK(conv_three_start_mode, exp_mode(v[7:5]))
    `CHK(conv_three_start_slot, exp_slot(v[7:5]))
    `CHK(conv_four_code, c4)
    `CHK(conv_four_start_mv, exp_mv(c4))
    `CHK(conv_three_code, c3)
    `CHK(conv_three_start_mv, exp_mv(c3))
    apb(1'b0, cscr_pkg::CFG_ADDR, 32'h0000_0000, 4'h0, 1'b0);
    `CHK(rdata, {16'h0000, v})
  endtask : chk_dec

  initial begin
    logic [15:0] v;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_dec(16'h0000);
    // every slot code on both converters
    for (int i = 0; i < 8; i++) begin
      v = {3'(i), 5'h15, 3'(7 - i), 5'h0A};
      wr_cfg({16'h0000, v}, 4'hF);
      chk_dec(v);
    end
    // every coarse voltage step, crossing into saturation
    for (int f = 0; f < 32; f++) begin
      conv_four_code_low <= 2'(f);
      conv_three_code_low <= ~2'(f);
      v = {3'h1, 5'(f), 3'h5, 5'(31 - f)};
      wr_cfg({16'h0000, v}, 4'hF);
      chk_dec(v);
    end
    // byte strobes and bits above the register width
    wr_cfg(32'hFFFF_FFFF, 4'hF);
    chk_dec(16'hFFFF);
    wr_cfg(32'h0000_0000, 4'h1);
    chk_dec(16'hFF00);
    // unmapped place: refused, no side effect
    apb(1'b1, cscr_pkg::CFG_ADDR + 18'h0_0004, 32'h0000_1234, 4'hF, 1'b0);
    `CHK(serr, 1'b1)
    apb(1'b0, cscr_pkg::CFG_ADDR + 18'h0_0004, 32'h0000_0000, 4'h0, 1'b0);
    `CHK(serr, 1'b1)
    `CHK(rdata, 32'h0000_0000)
    chk_dec(16'hFF00);
    // high lane only: low lane must keep its value
    wr_cfg(32'h0000_1234, 4'h2);
    chk_dec(16'h1200);
    // bootstrap load beats a same-cycle software write
    boot_load_data <= 16'hC3A5;
    apb(1'b1, cscr_pkg::CFG_ADDR, 32'h0000_1234, 4'hF, 1'b1);
    chk_dec(16'hC3A5);
    apb(1'b0, cscr_pkg::STAT_ADDR, 32'h0000_0000, 4'h0, 1'b0);
    `CHK(rdata, 32'h0000_0049)
    apb(1'b1, cscr_pkg::STAT_ADDR, 32'h0000_0001, 4'hF, 1'b0);
    apb(1'b0, cscr_pkg::STAT_ADDR, 32'h0000_0000, 4'h0, 1'b0);
    `CHK(rdata, 32'h0000_0048)
    // second reset in mid-run clears the fields
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_dec(16'h0000);
    end_of_test;
  end
endmodule : cscr_top_bench
